// >>> verilog/sdr_pkg.sv
package sdr_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LAT  = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DLL_BIT  = 2;
  localparam int LAT_AL_LSB    = 0;
  localparam int LAT_CL_LSB    = 8;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_UNDR_BIT = 9;
  localparam int STAT_CNT_LSB  = 10;

  localparam logic [2:0] CTRL_RESET = 3'h4;
  localparam logic [4:0] AL_RESET   = 5'h00;
  localparam logic [4:0] CL_RESET   = 5'h0b;

  // ----------------------------------------------------------------
  // Burst field encodings of mode register zero
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_BURST_EIGHT = 2'h0;
  localparam logic [1:0] MODE_PER_COMMAND = 2'h1;
  localparam logic [1:0] MODE_CHOP_FOUR   = 2'h2;

  // ----------------------------------------------------------------
  // Counts and sizes
  // ----------------------------------------------------------------
  localparam logic [2:0] BURST_EIGHT_CK = 3'h4;
  localparam logic [2:0] BURST_CHOP_CK  = 3'h2;
  localparam int PEND_DEPTH = 64;
  localparam int FIFO_DEPTH = 8;
  localparam int DQ_W       = 8;
  localparam int WORD_W     = 16;
  localparam int BANKS      = 8;
  localparam int CNT_W      = 4;

  typedef struct packed {
    logic       rd;
    logic       act;
    logic       burst_select_address_bit;
    logic       autoprecharge_address_bit;
    logic [2:0] bank;
  } sdr_cmd_t;

  typedef struct packed {
    logic       chop;
    logic       ap;
    logic [2:0] bank;
  } sdr_burst_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_BURST = 2'b10
  } sdr_state_t;

endpackage

// >>> verilog/sdr_sync.sv
`timescale 1ns/1ps
module sdr_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // First stage is read by the second stage only
  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// >>> verilog/sdr_fifo.sv
`timescale 1ns/1ps
module sdr_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic      [W-1:0]  out_data,
  output logic      [CW-1:0] count
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  assign in_ready  = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // ----------------------------------------------------------------
  // Pointers wrap naturally: depth must be a power of two
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + PW'(1);
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end
endmodule

// >>> verilog/sdr_read_burst_path.sv
// Function
// - Reads run as fixed eight, fixed chop-four, or per-command choice
// - Per-command mode: select bit low gives chop four, high gives eight
// - Autoprecharge bit low: plain read, bank stays open afterwards
// - Autoprecharge bit high: bank precharged once the burst completes
// - Eight beats when field is fixed eight, or per-command with bit high
// - Data starts additive plus column latency clocks after the read
// - Data lines released four or two clocks after read latency
// - Latency behaviour holds only with the delay loop locked
// - Chop four when field is fixed chop, or per-command with bit low
`timescale 1ns/1ps
module sdr_read_burst_path (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        LINK_CK,
  input  wire logic        CMD_RD,
  input  wire logic        CMD_ACT,
  input  wire logic        BURST_SELECT_ADDRESS_BIT,
  input  wire logic        AUTOPRECHARGE_ADDRESS_BIT,
  input  wire logic [2:0]  BANK,
  output logic      [7:0]  DQ_OUT,
  output logic             DQ_OE_N,
  output logic             DQS_OUT,
  output logic             DQS_OE_N
);
  // ----------------------------------------------------------------
  // Link inputs through the synchroniser
  // ----------------------------------------------------------------
  sdr_pkg::sdr_cmd_t cmd_raw;
  sdr_pkg::sdr_cmd_t cmd;
  logic              ck_s;
  logic              ck_d;

  assign cmd_raw = '{rd: CMD_RD, act: CMD_ACT,
                     burst_select_address_bit: BURST_SELECT_ADDRESS_BIT,
                     autoprecharge_address_bit: AUTOPRECHARGE_ADDRESS_BIT,
                     bank: BANK};

  sdr_sync #(.W(8)) u_sync (
    .clk (CLK),
    .rst (RST),
    .d   ({LINK_CK, cmd_raw}),
    .q   ({ck_s, cmd})
  );

  // Link clock is slow against CLK, so edges are found by sampling
  wire ck_rise = ck_s && !ck_d;
  wire ck_fall = !ck_s && ck_d;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [1:0]  burst_mode;
  logic        dll_locked;
  logic [4:0]  additive_latency;
  logic [4:0]  column_access_latency;
  logic        underrun;
  logic [7:0]  bank_open;
  logic        ph_write;
  logic        ph_data;
  logic [7:0]  ph_addr;

  // ----------------------------------------------------------------
  // AHB-Lite decode
  // ----------------------------------------------------------------
  wire       addr_ok  = HSEL && HTRANS[1] && HREADY;
  wire [7:0] addr_lo  = HADDR[7:0];
  wire       wr_reg   = ph_write && !ph_data;
  wire       wr_ctrl  = wr_reg && (ph_addr == sdr_pkg::OFS_CTRL);
  wire       wr_lat   = wr_reg && (ph_addr == sdr_pkg::OFS_LAT);
  wire       wr_stat  = wr_reg && (ph_addr == sdr_pkg::OFS_STAT);

  // ----------------------------------------------------------------
  // Read-data FIFO: a full FIFO stalls the bus via HREADYOUT
  // ----------------------------------------------------------------
  logic                      fifo_in_ready;
  logic                      fifo_out_valid;
  logic [sdr_pkg::WORD_W-1:0] fifo_out_data;
  logic [sdr_pkg::CNT_W-1:0]  fifo_count;
  logic                      pop;
  wire                       push = ph_data && fifo_in_ready;

  sdr_fifo #(.W(sdr_pkg::WORD_W), .DEPTH(sdr_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (CLK),
    .rst       (RST),
    .in_valid  (ph_data),
    .in_ready  (fifo_in_ready),
    .in_data   (HWDATA[sdr_pkg::WORD_W-1:0]),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data),
    .count     (fifo_count)
  );

  // ----------------------------------------------------------------
  // Burst selection and latency
  // ----------------------------------------------------------------
  logic [5:0] read_latency_total;
  logic [5:0] tap;

  assign read_latency_total = {1'b0, additive_latency} +
                              {1'b0, column_access_latency};
  assign tap = (read_latency_total == 6'h00) ? 6'h00
             : read_latency_total - 6'h01;

  wire per_command_burst_select = (burst_mode == sdr_pkg::MODE_PER_COMMAND);
  wire new_chop = (burst_mode == sdr_pkg::MODE_CHOP_FOUR) ||
                  (per_command_burst_select &&
                   !cmd.burst_select_address_bit);

  // reads are taken only with the delay loop locked
  wire take_read = ck_rise && cmd.rd && dll_locked;

  // ----------------------------------------------------------------
  // Pending reads, one slot per link clock
  // ----------------------------------------------------------------
  logic [sdr_pkg::PEND_DEPTH-1:0] pend_v;
  sdr_pkg::sdr_burst_t            pend_q [sdr_pkg::PEND_DEPTH];

  // No reset on the slots: only entries flagged in pend_v are ever used
  always_ff @(posedge CLK) begin
    if (ck_rise) begin
      pend_q[0] <= '{chop: new_chop,
                     ap: cmd.autoprecharge_address_bit,
                     bank: cmd.bank};
      for (int i = 1; i < sdr_pkg::PEND_DEPTH; i++) begin
        pend_q[i] <= pend_q[i-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Burst engine
  // ----------------------------------------------------------------
  sdr_pkg::sdr_state_t  state;
  sdr_pkg::sdr_burst_t  cur;
  logic [2:0]           beats_left;
  logic [7:0]           hi_byte;

  wire                 start      = ck_rise && pend_v[tap];
  sdr_pkg::sdr_burst_t start_info;
  assign start_info = pend_q[tap];
  wire in_burst   = (state == sdr_pkg::ST_BURST);
  wire last_done  = in_burst && (beats_left == 3'h0);
  wire can_start  = !in_burst || last_done;
  wire go         = start && can_start;
  wire cont       = ck_rise && in_burst && (beats_left != 3'h0);
  wire [2:0] len  = start_info.chop ? sdr_pkg::BURST_CHOP_CK
                                    : sdr_pkg::BURST_EIGHT_CK;
  wire close_ap   = ck_rise && last_done && cur.ap;
  wire [15:0] word = fifo_out_valid ? fifo_out_data : 16'h0000;

  assign pop = fifo_out_valid && (go || cont);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ck_d       <= 1'b0;
      pend_v     <= '0;
      state      <= sdr_pkg::ST_IDLE;
      cur        <= '0;
      beats_left <= 3'h0;
      hi_byte    <= 8'h00;
      DQ_OUT     <= 8'h00;
      DQ_OE_N    <= 1'b1;
      DQS_OUT    <= 1'b0;
      DQS_OE_N   <= 1'b1;
    end else begin
      ck_d <= ck_s;
      if (ck_rise) begin
        pend_v <= {pend_v[sdr_pkg::PEND_DEPTH-2:0], take_read};
      end
      unique case (state)
        sdr_pkg::ST_IDLE: begin
          if (go) begin
            state <= sdr_pkg::ST_BURST;
          end
        end
        sdr_pkg::ST_BURST: begin
          if (ck_rise && last_done && !go) begin
            state    <= sdr_pkg::ST_IDLE;
            DQ_OE_N  <= 1'b1;
            DQS_OE_N <= 1'b1;
            DQS_OUT  <= 1'b0;
          end
        end
        // A corrupted one-hot code falls back to idle
        default: begin
          state <= sdr_pkg::ST_IDLE;
        end
      endcase
      // first beat on the rising half, second on the falling
      if (go || cont) begin
        DQ_OUT     <= word[7:0];
        hi_byte    <= word[15:8];
        DQ_OE_N    <= 1'b0;
        DQS_OUT    <= 1'b1;
        DQS_OE_N   <= 1'b0;
        beats_left <= go ? len - 3'h1 : beats_left - 3'h1;
      end
      if (go) begin
        cur <= start_info;
      end
      if (ck_fall && in_burst && !DQ_OE_N) begin
        DQ_OUT  <= hi_byte;
        DQS_OUT <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bank open flags, one per bank
  // ----------------------------------------------------------------
  // open until autoprecharge; activate wins
  for (genvar b = 0; b < sdr_pkg::BANKS; b++) begin : g_bank
    wire hit_act = ck_rise && cmd.act && (cmd.bank == 3'(b));
    wire hit_pre = close_ap && (cur.bank == 3'(b));

    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        bank_open[b] <= 1'b0;
      end else if (hit_act) begin
        bank_open[b] <= 1'b1;
      end else if (hit_pre) begin
        bank_open[b] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file and bus answer
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  assign rd_mux =
    (addr_lo == sdr_pkg::OFS_CTRL) ? {29'h0, dll_locked, burst_mode} :
    (addr_lo == sdr_pkg::OFS_LAT)  ? {19'h0, column_access_latency,
                                      3'h0, additive_latency} :
    (addr_lo == sdr_pkg::OFS_STAT) ? {18'h0, fifo_count, underrun,
                                      in_burst, bank_open} :
    32'h0000_0000;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      burst_mode            <= sdr_pkg::CTRL_RESET[1:0];
      dll_locked            <= sdr_pkg::CTRL_RESET[2];
      additive_latency      <= sdr_pkg::AL_RESET;
      column_access_latency <= sdr_pkg::CL_RESET;
      underrun              <= 1'b0;
      ph_write              <= 1'b0;
      ph_data               <= 1'b0;
      ph_addr               <= 8'h00;
      HRDATA                <= 32'h0000_0000;
      HREADYOUT             <= 1'b1;
      HRESP                 <= 1'b0;
    end else begin
      if (HREADYOUT) begin
        ph_write <= addr_ok && HWRITE;
        ph_addr  <= addr_lo;
        HRDATA   <= rd_mux;
      end
      // Data pushes take one wait state, longer while the FIFO is full
      if (addr_ok && HWRITE && HREADYOUT &&
          addr_lo == sdr_pkg::OFS_DATA) begin
        ph_data   <= 1'b1;
        HREADYOUT <= 1'b0;
      end else if (push) begin
        ph_data   <= 1'b0;
        HREADYOUT <= 1'b1;
      end
      if (wr_ctrl) begin
        burst_mode <= HWDATA[sdr_pkg::CTRL_MODE_LSB +: 2];
        dll_locked <= HWDATA[sdr_pkg::CTRL_DLL_BIT];
      end
      if (wr_lat) begin
        additive_latency      <= HWDATA[sdr_pkg::LAT_AL_LSB +: 5];
        column_access_latency <= HWDATA[sdr_pkg::LAT_CL_LSB +: 5];
      end
      // Underrun set beats a clear in the same cycle
      if ((go || cont) && !fifo_out_valid) begin
        underrun <= 1'b1;
      end else if (wr_stat && HWDATA[sdr_pkg::STAT_UNDR_BIT]) begin
        underrun <= 1'b0;
      end
    end
  end
endmodule

// >>> testbench/sdr_read_burst_path_monitor.sv
`timescale 1ns/1ps
module sdr_read_burst_path_monitor (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic [7:0]  DQ_OUT,
  input wire logic        DQ_OE_N,
  input wire logic        DQS_OUT,
  input wire logic        DQS_OE_N
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [5:0] low_cnt;
  wire        addr_ph = HSEL && HTRANS[1] && HREADY;

  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  // Link clock is an exact multiple of CLK, so drive time is exact
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) low_cnt <= 6'h00;
    else if (DQ_OE_N) low_cnt <= 6'h00;
    else low_cnt <= low_cnt + 6'h01;
  end

  sequence s_hi;
    DQS_OUT [*4];
  endsequence

  chk_strobe_half: assert property (
    !DQ_OE_N && $rose(DQS_OUT) |-> s_hi ##1 !DQS_OUT)
    else $error("strobe high time wrong");
  chk_first_beat: assert property (
    $fell(DQ_OE_N) |-> DQS_OUT)
    else $error("first beat strobe low");
  chk_oe_pair: assert property (
    DQ_OE_N == DQS_OE_N)
    else $error("data and strobe enables differ");
  chk_drive_len: assert property (
    $rose(DQ_OE_N) |-> low_cnt == 6'h10 || low_cnt == 6'h20)
    else $error("drive length wrong");
  chk_release_low: assert property (
    $rose(DQ_OE_N) |-> !$past(DQS_OUT))
    else $error("released before second beat");
  chk_beat_steady: assert property (
    !DQ_OE_N && $changed(DQ_OUT) |-> $changed(DQS_OUT))
    else $error("data changed without strobe");
  chk_quick_ready: assert property (
    addr_ph && HADDR[7:0] != sdr_pkg::OFS_DATA |=> HREADYOUT)
    else $error("register phase stalled");
  chk_data_wait: assert property (
    addr_ph && HWRITE && HADDR[7:0] == sdr_pkg::OFS_DATA |=> !HREADYOUT)
    else $error("data push did not wait");
  chk_unmapped_zero: assert property (
    addr_ph && !HWRITE && HADDR[7:4] != 4'h0 |=> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  chk_okay_resp: assert property (HRESP == 1'b0)
    else $error("response not okay");
endmodule

bind sdr_read_burst_path sdr_read_burst_path_monitor u_mon (
  .CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY, .HRDATA,
  .HREADYOUT, .HRESP, .DQ_OUT, .DQ_OE_N, .DQS_OUT, .DQS_OE_N);

// >>> testbench/sdr_ctrl_model.sv
`timescale 1ns/1ps
module sdr_ctrl_model (
  output logic       link_ck,
  output logic       cmd_rd,
  output logic       cmd_act,
  output logic       bsel,
  output logic       ap,
  output logic [2:0] bank
);
  // ----------------------------------------------------------------
  // Controller model
  // ----------------------------------------------------------------
  initial begin
    link_ck = 1'b0;
    cmd_rd = 1'b0;
    cmd_act = 1'b0;
    bsel = 1'b0;
    ap = 1'b0;
    bank = 3'h0;
    #37;
    forever #400 link_ck = ~link_ck;
  end

  task automatic send(input logic rd, sb, a, input logic [2:0] b);
    @(negedge link_ck);
    cmd_rd <= rd;
    cmd_act <= !rd;
    bsel <= sb;
    ap <= a;
    bank <= b;
    @(negedge link_ck);
    cmd_rd <= 1'b0;
    cmd_act <= 1'b0;
    // Stale address bits inverted so a late sample never passes
    bsel <= !sb;
    ap <= !a;
    bank <= ~b;
  endtask
endmodule

// >>> testbench/sdr_read_burst_path_tb.sv
`timescale 1ns/1ps
module sdr_read_burst_path_tb;
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  localparam logic [1:0] cfg_mode [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
  localparam logic       cfg_sb   [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  localparam logic       cfg_ap   [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  localparam int         cfg_nck  [5] = '{4, 4, 2, 2, 4};
  logic        clk, rst, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic        link_ck, cmd_rd, cmd_act, bsel, ap;
  logic [2:0]  bank;
  logic [7:0]  dq, open;
  logic        dq_oe_n, dqs, dqs_oe_n;
  logic [15:0] expq [$];
  int          n_fail, total_checks;

  sdr_read_burst_path u_dut (
    .CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
    .HRESP(hresp), .LINK_CK(link_ck), .CMD_RD(cmd_rd),
    .CMD_ACT(cmd_act), .BURST_SELECT_ADDRESS_BIT(bsel),
    .AUTOPRECHARGE_ADDRESS_BIT(ap), .BANK(bank), .DQ_OUT(dq),
    .DQ_OE_N(dq_oe_n), .DQS_OUT(dqs), .DQS_OE_N(dqs_oe_n));

  sdr_ctrl_model u_ctl (
    .link_ck(link_ck), .cmd_rd(cmd_rd), .cmd_act(cmd_act),
    .bsel(bsel), .ap(ap), .bank(bank));

  always #50 clk = ~clk;

  task automatic finish_test;
    if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Slave may stall either phase; the watchdog bounds each wait
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic push(input logic [15:0] w);
    expq.push_back(w);
    ahb(1'b1, sdr_pkg::OFS_DATA, {16'h0, w});
  endtask

  // Beat n is looked at on the link edge after the one that sends it
  task automatic burst(input logic sb, a, input logic [2:0] b,
                       input int nck, lat);
    logic [15:0] w;
    logic        on;
    u_ctl.send(1'b1, sb, a, b);
    for (int k = 1; k <= lat + nck; k++) begin
      @(negedge link_ck);
      on = k >= lat && k < lat + nck;
      w = 16'h0;
      if (on && expq.size() > 0) w = expq.pop_front();
      chk(dq_oe_n, !on);
      if (on) begin
        chk({dqs, dq}, {1'b1, w[7:0]});
        @(posedge link_ck);
        chk({dqs, dq}, {1'b0, w[15:8]});
      end
    end
  endtask

  initial begin
    #1_000_000;
    n_fail++;
    finish_test;
  end

  initial begin
    {clk, hsel, hwrite, htrans, haddr, hwdata, open} = '0;
    rst = 1'b1;
    n_fail = 0;
    total_checks = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rc(sdr_pkg::OFS_CTRL, 32'h4);
    rc(sdr_pkg::OFS_LAT, 32'h0b00);
    ahb(1'b1, 8'h10, 32'hffff_ffff);
    rc(8'h10, 32'h0);
    rc(sdr_pkg::OFS_DATA, 32'h0);
    rc(sdr_pkg::OFS_STAT, 32'h0);
    ahb(1'b1, sdr_pkg::OFS_LAT, 32'h0b0a);
    rc(sdr_pkg::OFS_LAT, 32'h0b0a);
    for (int i = 0; i < 5; i++) begin
      ahb(1'b1, sdr_pkg::OFS_CTRL, {29'h1, cfg_mode[i]});
      u_ctl.send(1'b0, 1'b0, 1'b0, 3'(i + 1));
      open[i+1] = 1'b1;
      for (int j = 0; j < cfg_nck[i]; j++)
        push({8'(i * 16 + j), 8'(8'ha5 ^ j)});
      burst(cfg_sb[i], cfg_ap[i], 3'(i + 1), cfg_nck[i], 21);
      if (cfg_ap[i]) open[i+1] = 1'b0;
      rc(sdr_pkg::OFS_STAT, {24'h0, open});
    end
    ahb(1'b1, sdr_pkg::OFS_CTRL, 32'h6);
    burst(1'b0, 1'b0, 3'h0, 2, 21);
    rc(sdr_pkg::OFS_STAT, {22'h0, 2'h2, open});
    ahb(1'b1, sdr_pkg::OFS_STAT, 32'h200);
    rc(sdr_pkg::OFS_STAT, {24'h0, open});
    push(16'h1234);
    push(16'h5678);
    ahb(1'b1, sdr_pkg::OFS_CTRL, 32'h0);
    burst(1'b1, 1'b0, 3'h1, 0, 25);
    rc(sdr_pkg::OFS_STAT, {18'h0, 4'h2, 2'h0, open});
    ahb(1'b1, sdr_pkg::OFS_CTRL, 32'h4);
    for (int j = 0; j < 6; j++) push({8'(j), 8'h77});
    rc(sdr_pkg::OFS_STAT, {18'h0, 4'h8, 2'h0, open});
    fork
      push(16'hbeef);
      burst(1'b1, 1'b0, 3'h2, 4, 21);
    join
    rc(sdr_pkg::OFS_STAT, {18'h0, 4'h5, 2'h0, open});
    burst(1'b1, 1'b0, 3'h2, 4, 21);
    ahb(1'b1, sdr_pkg::OFS_CTRL, 32'h6);
    burst(1'b1, 1'b0, 3'h2, 2, 21);
    rc(sdr_pkg::OFS_STAT, {22'h0, 2'h2, open});
    finish_test;
  end
endmodule
